// file: core/ddsip_pkg.sv
// Purpose: shared constants for the dual converter serial input port
// Assumes: a 16-bit frame, control byte first, most significant bit first
// Notes:   control byte layout beyond the reference select bit is kept raw
package ddsip_pkg;
	localparam int          DDSIP_FRAME_BITS   = 16;       // bits in one frame
	localparam int          DDSIP_BYTE_BITS    = 8;        // data and control width
	localparam int          DDSIP_REF_SEL_POS  = 2;        // reference select bit in control
	localparam logic [7:0]  DDSIP_DATA_RESET   = 8'h00;    // converter code after reset
	localparam logic [7:0]  DDSIP_CTRL_RESET   = 8'h00;    // control byte after reset
	localparam logic [4:0]  DDSIP_CNT_FULL     = 5'h10;    // count at a complete frame
	localparam int          DDSIP_SCLK_MAX_MHZ = 30;       // fastest serial clock allowed
endpackage

// file: core/ddsip_port.sv
// Purpose: serial input port of a dual 8-bit converter, three-wire link
// Assumes: link clock runs only inside frames; frame_n high between frames
// Notes:   shifting runs on the link clock; the frame end is caught on clk
//
// Functional notes
// - sample data on rising link clock in frame
// - sixteen bits: eight data, eight control
// - low frame signal enables shifting from then
// - frame rising edge updates data and control
// - reference select one picks external reference
// - data is straight binary code 0 to 255
`timescale 1ns/10ps
module ddsip_port #(
	parameter int FRAME_BITS = ddsip_pkg::DDSIP_FRAME_BITS   // bits per frame
) (
	input  wire logic       clk,                // system clock, 20 MHz
	input  wire logic       rst_n,              // asynchronous reset, active low
	input  wire logic       sclk,               // link clock from the host
	input  wire logic       din,                // serial data from the host
	input  wire logic       frame_n,            // frame signal, active low
	output logic [7:0]      dac_code,           // converter code, straight binary
	output logic [7:0]      ctrl_byte,          // last accepted control byte
	output logic            ref_source_select,  // 1 external, 0 internal reference
	output logic            update_pulse        // one clk cycle per accepted frame
);
	// link domain: everything here runs on the host's serial clock, bar the frame_n clear of bit_cnt
	logic [FRAME_BITS-1:0]  shift_reg;          // incoming bits
	logic [4:0]             bit_cnt;            // bits taken this frame
	logic [FRAME_BITS-1:0]  hold_word;          // word handed to clk domain
	logic                   hold_toggle;        // flips when a full word is held

	// shift on rising link clock, msb first
	// not cleared between frames; only a full count ever publishes it
	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			shift_reg <= '0;
		end else if (!frame_n) begin
			// only accept bits while the frame is low
			shift_reg <= {shift_reg[FRAME_BITS-2:0], din};
		end
	end

	// count to sixteen bits per frame
	// the link clock is still between frames, so a high frame signal has to
	// clear the count by itself; otherwise a frame would go on counting
	// from wherever the last one stopped, a short frame above all
	always_ff @(posedge sclk or negedge rst_n or posedge frame_n) begin
		if (!rst_n) begin
			bit_cnt <= 5'h00;
		end else if (frame_n) begin
			// frame high: idle, ready for the next first bit
			bit_cnt <= 5'h00;
		end else if (bit_cnt != ddsip_pkg::DDSIP_CNT_FULL) begin
			// saturate at a full frame so later bits cannot wrap the count
			bit_cnt <= bit_cnt + 5'h01;
		end
	end

	// publish a word only at the sixteenth bit; later bits are ignored
	// the toggle tells the clk side that a new word stands; hold_word keeps
	// still until the next frame's sixteenth bit, far beyond the sync delay
	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			hold_word   <= '0;
			hold_toggle <= 1'b0;
		end else if (!frame_n && bit_cnt == ddsip_pkg::DDSIP_CNT_FULL - 5'h01) begin
			hold_word   <= {shift_reg[FRAME_BITS-2:0], din};
			hold_toggle <= ~hold_toggle;
		end
	end

	// clk domain: frame end detection and the output registers
	logic [2:0]             frame_sync;         // frame_n through three flops
	logic [2:0]             tog_sync;           // hold_toggle through three flops
	logic                   frame_level;        // filtered frame level
	logic                   frame_rise;         // frame end seen on clk
	logic                   frame_end;          // frame end, one cycle later
	logic                   tog_new;            // a new word has just crossed
	logic                   tog_seen;           // toggle value already used
	logic                   word_pending;       // full word arrived this frame

	// three-stage sampling; stage 0 feeds only stage 1
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			frame_sync <= 3'h7;
			tog_sync   <= 3'h0;
		end else begin
			frame_sync <= {frame_sync[1:0], frame_n};
			tog_sync   <= {tog_sync[1:0], hold_toggle};
		end
	end

	// a level change counts once stages two and three agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			frame_level <= 1'b1;
		end else if (frame_sync[2] == frame_sync[1]) begin
			frame_level <= frame_sync[2];
		end
	end

	// frame end: filtered level still low while the last two stages read high
	assign frame_rise = !frame_level && frame_sync[2] && frame_sync[1];

	// delay the frame end by one cycle; the toggle leaves the link side
	// before the frame ends, but sampling may still see it one cycle late
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			frame_end <= 1'b0;
		end else begin
			frame_end <= frame_rise;
		end
	end

	// a toggle counts once stages two and three agree on a new value
	assign tog_new = (tog_sync[2] == tog_sync[1]) && (tog_sync[2] != tog_seen);

	// remember which toggle value has been used
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tog_seen <= 1'b0;
		end else if (tog_new) begin
			tog_seen <= tog_sync[2];
		end
	end

	// a word is pending from its toggle until the frame end
	// a toggle landing in the frame end cycle is used by that very update,
	// so the end wins here and nothing is left over for the next frame
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			word_pending <= 1'b0;
		end else if (frame_end) begin
			word_pending <= 1'b0;
		end else if (tog_new) begin
			word_pending <= 1'b1;
		end
	end

	// frame rising edge loads the registers; code kept as binary
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dac_code          <= ddsip_pkg::DDSIP_DATA_RESET;
			ctrl_byte         <= ddsip_pkg::DDSIP_CTRL_RESET;
			ref_source_select <= 1'b0;
			update_pulse      <= 1'b0;
		end else begin
			update_pulse <= 1'b0;
			// short frames leave nothing pending and are dropped
			// a word whose toggle arrives in the end cycle still counts
			if (frame_end && (word_pending || tog_new)) begin
				// first byte is control, second byte the code
				ctrl_byte    <= hold_word[15:8];
				dac_code     <= hold_word[7:0];
				// control bit 2 set to one selects external reference
				ref_source_select <= hold_word[8 + ddsip_pkg::DDSIP_REF_SEL_POS];
				update_pulse <= 1'b1;
			end
		end
	end

	// checks: each one guards a rule on what this block drives
	// clk-side checks, with the two on the link clock placed after the short-frame check

	// update only at a frame end
	a_update_on_end: assert property (@(posedge clk) disable iff (!rst_n)
		update_pulse |-> $past(frame_end) && ($past(word_pending) || $past(tog_new)))
		else $error("update without frame end");

	a_ref_follows: assert property (@(posedge clk) disable iff (!rst_n)
		update_pulse |-> ref_source_select == ctrl_byte[ddsip_pkg::DDSIP_REF_SEL_POS])
		else $error("reference select not from control byte");

	a_regs_stable: assert property (@(posedge clk) disable iff (!rst_n)
		!update_pulse |-> $stable(dac_code) && $stable(ctrl_byte))
		else $error("registers changed without update");

	a_pulse_single: assert property (@(posedge clk) disable iff (!rst_n)
		update_pulse |=> !update_pulse)
		else $error("update pulse too long");

	a_short_drop: assert property (@(posedge clk) disable iff (!rst_n)
		frame_end && !word_pending && !tog_new |=> !update_pulse)
		else $error("short frame updated registers");

	a_count_limit: assert property (@(posedge sclk) disable iff (!rst_n)
		bit_cnt <= ddsip_pkg::DDSIP_CNT_FULL)
		else $error("bit count past frame length");

	a_shift_msb: assert property (@(posedge sclk) disable iff (!rst_n)
		!frame_n |=> shift_reg[0] == $past(din))
		else $error("data not shifted in");

	a_data_word: assert property (@(posedge clk) disable iff (!rst_n)
		update_pulse |-> {ctrl_byte, dac_code} == hold_word)
		else $error("data or control misplaced");

	a_end_single: assert property (@(posedge clk) disable iff (!rst_n)
		frame_end |=> !frame_end)
		else $error("frame end seen twice");

	a_update_idle: assert property (@(posedge clk) disable iff (!rst_n)
		update_pulse |-> frame_level)
		else $error("update while frame still low");

	a_pending_clear: assert property (@(posedge clk) disable iff (!rst_n)
		frame_end |=> !word_pending)
		else $error("word left pending after frame end");
endmodule // ddsip_port

// file: verif/ddsip_host_model.sv
// Purpose: host side of the three-wire link, drives frames into the port
// Assumes: link clock period 34 ns, still between frames
// Notes:   data line flips after the frame so a stale bit is never seen
`timescale 1ns/10ps
module ddsip_host_model (
	output logic sclk,    // link clock, idle low
	output logic din,     // serial data
	output logic frame_n  // frame, active low
);
	// idle link at time zero
	initial begin
		sclk = 1'b0;
		din = 1'b0;
		frame_n = 1'b1;
	end
	// frame low first, at most 30 MHz, msb first
	task automatic send(input logic [15:0] word, input int n);
		frame_n = 1'b0;
		for (int i = 15; i > 15 - n; i--) begin
			din = word[i];
			#17 sclk = 1'b1;
			#17 sclk = 1'b0;
		end
		#17 frame_n = 1'b1;
		din = ~din;
	endtask
endmodule // ddsip_host_model

// file: verif/dual_dac_serial_input_port_test.sv
// Purpose: self-checking bench of the serial input port
// Assumes: host model on the link, 50 ns system clock
// Notes:   a short frame must leave every output untouched
`timescale 1ns/10ps
module dual_dac_serial_input_port_test;
	logic       clk, rst_n, sclk, din, frame_n, ref_source_select, update_pulse;
	logic [7:0] dac_code, ctrl_byte;
	int         n_fail = 0;
	int         n_tests = 0;
	// system clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	ddsip_port ddsip_port_inst (.clk(clk), .rst_n(rst_n), .sclk(sclk), .din(din),
		.frame_n(frame_n), .dac_code(dac_code), .ctrl_byte(ctrl_byte),
		.ref_source_select(ref_source_select), .update_pulse(update_pulse));
	ddsip_host_model ddsip_host_model_inst (.sclk(sclk), .din(din), .frame_n(frame_n));
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// one frame, then count pulses over a bounded window
	task automatic frame(input logic [15:0] w, input int n, input logic [7:0] npulse);
		logic [7:0] seen;
		seen = 8'h00;
		@(negedge clk);
		ddsip_host_model_inst.send(w, n);
		repeat (10) begin
			@(negedge clk);
			if (update_pulse === 1'b1) seen++;
		end
		check("update_pulse", seen, npulse);
	endtask
	task automatic test_full(input logic [7:0] c, input logic [7:0] d);
		frame({c, d}, 16, 8'h01);
		check("dac_code", dac_code, d);
		check("ctrl_byte", ctrl_byte, c);
		check("ref_select", {7'h00, ref_source_select}, {7'h00, c[ddsip_pkg::DDSIP_REF_SEL_POS]});
		$display("full frame %h %h done", c, d);
	endtask
	task automatic test_short(input logic [7:0] c, input logic [7:0] d);
		frame(16'h5a3c, 10, 8'h00);
		check("dac_code", dac_code, d);
		check("ctrl_byte", ctrl_byte, c);
		$display("short frame done");
	endtask
	// reset for 12 cycles; every output reads zero before release
	task automatic test_reset();
		rst_n = 1'b0;
		repeat (12) @(negedge clk);
		check("dac_code", dac_code, ddsip_pkg::DDSIP_DATA_RESET);
		check("ctrl_byte", ctrl_byte, ddsip_pkg::DDSIP_CTRL_RESET);
		check("ref_select", {7'h00, ref_source_select}, 8'h00);
		check("update_pulse", {7'h00, update_pulse}, 8'h00);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		$display("reset done");
	endtask
	initial begin
		test_reset();
		test_full(8'h04, 8'ha5);
		test_full(8'h00, 8'hff);
		test_short(8'h00, 8'hff);
		test_full(8'hfb, 8'h00);
		test_reset();
		test_full(8'h04, 8'h3c);
		print_verdict();
	end
endmodule // dual_dac_serial_input_port_test
